/* File: logic/dir_part_identifier_word_info_rom.sv */
// Read-only identification words and factory information area behind an APB slave.
// Assumes an APB master on core_clk and an asynchronous bulk-erase request pin.
`timescale 1ns/100ps
module dir_part_identifier_word_info_rom #(
    parameter logic [11:0] PART_NUMBER = dir_pkg::PART_NUMBER_DEFAULT,
    parameter logic [5:0] MAJOR_REV = dir_pkg::MAJOR_REV_DEFAULT,
    parameter logic [5:0] MINOR_REV = dir_pkg::MINOR_REV_DEFAULT,
    parameter bit LOW_VOLTAGE = 1'b0,
    parameter int ADDR_W = dir_pkg::APB_ADDR_W,
    parameter dir_pkg::dir_image_t FACTORY_IMAGE = dir_pkg::FACTORY_IMAGE_DEFAULT
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bulk_erase_req
);
    import dir_pkg::*;

    generate
        if (ADDR_W < APB_ADDR_W) begin : g_bad_addr_w
            $error("ADDR_W too narrow for the information area");
        end
    endgenerate

    typedef struct packed {
        logic [WORD_W-1:0] rdata;
        logic rd_err;
        logic write_refused;
        logic erase_refused;
        logic erase_sync1;
        logic erase_sync2;
        logic erase_sync3;
    } dir_state_s;

    dir_state_s state_r;
    dir_state_s state_nxt;

    dir_part_word_s part_word;
    dir_rev_word_s rev_word;
    logic [WORD_W-1:0] info_mem [INFO_WORDS];
    logic [15:0] word_idx;
    logic [4:0] info_off;
    logic setup_phase;
    logic access_phase;
    logic is_info;
    logic is_mapped;
    logic [WORD_W-1:0] lookup;

    always_comb begin
        part_word.marker = PART_ID_MARKER;
        part_word.part_number_field = PART_NUMBER;
        rev_word.marker = REVISION_MARKER;
        rev_word.major_revision_field = MAJOR_REV;
        rev_word.minor_revision_field = MINOR_REV;
    end

    // Contents come only from elaboration; no port reaches them
    generate
        for (genvar g = 0; g < INFO_WORDS; g++) begin : g_info_word
            localparam logic [15:0] LOC = IDX_INFO_FIRST + 16'(g);
            localparam bit TEMP_PAD = LOC == IDX_TEMP_LOW - 16'h0001
                || LOC == IDX_TEMP_LOW + 16'h0001
                || LOC == IDX_TEMP_HIGH - 16'h0001
                || LOC == IDX_TEMP_HIGH + 16'h0001;
            localparam bit NO_4X = LOW_VOLTAGE
                && (LOC == IDX_ADC_REF_4X || LOC == IDX_CMP_REF_4X);
            if (TEMP_PAD) begin : g_pad
                assign info_mem[g] = BLANK_WORD;
            end else if (NO_4X) begin : g_absent
                assign info_mem[g] = BLANK_WORD;
            end else begin : g_stored
                assign info_mem[g] = FACTORY_IMAGE[g];
            end
        end
    endgenerate

    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    // Word index from a byte address; bits above the index must be zero
    assign word_idx = (paddr[ADDR_W-1:2] >> 16 == '0) ? 16'(paddr[ADDR_W-1:2]) : 16'hffff;
    assign info_off = word_idx[4:0];
    assign is_info = word_idx >= IDX_INFO_FIRST && word_idx <= IDX_INFO_LAST;
    assign is_mapped = is_info || word_idx == IDX_REVISION || word_idx == IDX_PART_ID
        || word_idx == IDX_ACCESS_STATUS;

    always_comb begin
        lookup = '0;
        if (word_idx == IDX_PART_ID) begin
            lookup = part_word;
        end else if (word_idx == IDX_REVISION) begin
            lookup = rev_word;
        end else if (is_info) begin
            lookup = info_mem[info_off];
        end else if (word_idx == IDX_ACCESS_STATUS) begin
            lookup[STAT_WRITE_REFUSED_BIT] = state_r.write_refused;
            lookup[STAT_ERASE_REFUSED_BIT] = state_r.erase_refused;
        end
    end

    always_comb begin
        state_nxt = state_r;
        state_nxt.erase_sync1 = bulk_erase_req;
        state_nxt.erase_sync2 = state_r.erase_sync1;
        state_nxt.erase_sync3 = state_r.erase_sync2;
        // Data captured in setup so the access phase answers from flops
        if (setup_phase) begin
            state_nxt.rdata = pwrite ? '0 : lookup;
            state_nxt.rd_err = !is_mapped;
        end
        if (access_phase && pwrite && word_idx == IDX_ACCESS_STATUS && pstrb[0]) begin
            if (pwdata[STAT_WRITE_REFUSED_BIT]) begin
                state_nxt.write_refused = 1'b0;
            end
            if (pwdata[STAT_ERASE_REFUSED_BIT]) begin
                state_nxt.erase_refused = 1'b0;
            end
        end
        // Set after clear so a coincident event is kept
        if (access_phase && pwrite && is_mapped && word_idx != IDX_ACCESS_STATUS) begin
            state_nxt.write_refused = 1'b1;
        end
        if (state_r.erase_sync2 && !state_r.erase_sync3) begin
            state_nxt.erase_refused = 1'b1;
        end
        if (!rstn) begin
            state_nxt = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        state_r <= state_nxt;
    end

    assign pready = 1'b1;
    assign prdata = {18'h00000, state_r.rdata};
    assign pslverr = access_phase && state_r.rd_err;

endmodule

/* File: logic/dir_pkg.sv */
// Constants and types for the identification and factory information store.
// Assumes an APB slave; word indices below are program-space locations, byte = index*4.
package dir_pkg;

    localparam int WORD_W = 14;
    localparam int APB_ADDR_W = 18;
    localparam int INFO_WORDS = 32;

    // Word indices in program space
    localparam logic [15:0] IDX_REVISION = 16'h8005;
    localparam logic [15:0] IDX_PART_ID = 16'h8006;
    localparam logic [15:0] IDX_INFO_FIRST = 16'h8100;
    localparam logic [15:0] IDX_INFO_LAST = 16'h811f;
    localparam logic [15:0] IDX_UID_FIRST = 16'h8100;
    localparam logic [15:0] IDX_UID_RSVD = 16'h8109;
    localparam logic [15:0] IDX_TEMP_LOW = 16'h8113;
    localparam logic [15:0] IDX_TEMP_HIGH = 16'h8116;
    localparam logic [15:0] IDX_ADC_REF_1X = 16'h8118;
    localparam logic [15:0] IDX_ADC_REF_2X = 16'h8119;
    localparam logic [15:0] IDX_ADC_REF_4X = 16'h811a;
    localparam logic [15:0] IDX_CMP_REF_1X = 16'h811b;
    localparam logic [15:0] IDX_CMP_REF_2X = 16'h811c;
    localparam logic [15:0] IDX_CMP_REF_4X = 16'h811d;
    localparam logic [15:0] IDX_ACCESS_STATUS = 16'h8120;

    // Access status fields, write one to clear
    localparam int STAT_WRITE_REFUSED_BIT = 0;
    localparam int STAT_ERASE_REFUSED_BIT = 1;

    // Fixed marker bits of the two identification words
    localparam logic [1:0] PART_ID_MARKER = 2'h3;
    localparam logic [1:0] REVISION_MARKER = 2'h2;
    // Arbitrary values, not those of any real part
    localparam logic [11:0] PART_NUMBER_DEFAULT = 12'h0a5;
    localparam logic [5:0] MAJOR_REV_DEFAULT = 6'h01;
    localparam logic [5:0] MINOR_REV_DEFAULT = 6'h00;

    // Unassigned and absent words read like erased cells
    localparam logic [13:0] BLANK_WORD = 14'h3fff;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [1:0] marker;
        logic [11:0] part_number_field;
    } dir_part_word_s;

    typedef struct packed {
        logic [1:0] marker;
        logic [5:0] major_revision_field;
        logic [5:0] minor_revision_field;
    } dir_rev_word_s;

    typedef logic [INFO_WORDS-1:0][WORD_W-1:0] dir_image_t;

    // Plain default image; manufacture overrides it per part
    localparam dir_image_t FACTORY_IMAGE_DEFAULT = '{default: BLANK_WORD};

endpackage

/* File: verif/dir_apb_master.sv */
// APB master model standing for the memory read path.
// Assumes each transfer is started by the bench.
`timescale 1ns/100ps
module dir_apb_master (
    input wire logic core_clk,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [17:0] paddr,
    output logic [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // Waits an edge first, so back-to-back calls never drive psel twice in one step
    task automatic xfer(input logic [17:0] a, input logic w, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule

/* File: verif/dir_rom_monitor.sv */
// Port checker for the identification store.
// Bound onto the store; sees its ports only.
`timescale 1ns/100ps
module dir_rom_monitor #(
    parameter int ADDR_W = 18,
    parameter logic [11:0] PART_NUMBER = 12'h0,
    parameter logic [5:0] MAJOR_REV = 6'h0,
    parameter logic [5:0] MINOR_REV = 6'h0
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire logic acc = psel && penable;
    wire logic rd = acc && !pwrite;
    wire logic info = paddr >= 18'h20400 && paddr <= 18'h2047c;
    property p_id_mark; rd && paddr == 18'h20018 |-> prdata[13:12] == 2'b11; endproperty
    a_id_mark: assert property (p_id_mark) else $error("id marker");
    property p_id_num; rd && paddr == 18'h20018 |-> prdata[11:0] == PART_NUMBER; endproperty
    a_id_num: assert property (p_id_num) else $error("part number");
    property p_rev_mark; rd && paddr == 18'h20014 |-> prdata[13:12] == 2'b10; endproperty
    a_rev_mark: assert property (p_rev_mark) else $error("rev marker");
    property p_rev;
        rd && paddr == 18'h20014 |-> prdata[11:0] == {MAJOR_REV, MINOR_REV};
    endproperty
    a_rev: assert property (p_rev) else $error("revision");
    property p_upper; rd |-> prdata[31:14] == 18'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper bits");
    property p_info_ok; acc && info |-> !pslverr; endproperty
    a_info_ok: assert property (p_info_ok) else $error("info error");
    property p_ro_wr; acc && pwrite && info |-> prdata == 32'h0; endproperty
    a_ro_wr: assert property (p_ro_wr) else $error("write data");
    property p_unmapped; acc && paddr == 18'h20000 |-> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped");
    c_err: cover property (acc && pslverr);
    c_wr: cover property (acc && pwrite && info);
    c_rd: cover property (rd && info);
endmodule
bind dir_part_identifier_word_info_rom dir_rom_monitor #(.ADDR_W(ADDR_W), .PART_NUMBER(PART_NUMBER),
    .MAJOR_REV(MAJOR_REV), .MINOR_REV(MINOR_REV)) i_dir_rom_monitor (.core_clk(core_clk),
    .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pslverr(pslverr));

/* File: verif/test_part_identifier_word_info_rom.sv */
// Self-checking bench for the identification store.
// Assumes the master model and the bound checker.
`timescale 1ns/100ps
module test_part_identifier_word_info_rom;
    import dir_pkg::*;
    localparam logic [11:0] PN = 12'h5c3; // Arbitrary value
    function automatic dir_image_t mk_img();
        for (int i = 0; i < INFO_WORDS; i++) mk_img[i] = 14'h1000 + 14'(i);
    endfunction
    localparam dir_image_t IMG = mk_img();
    logic core_clk = 0, rstn = 0, bulk_erase_req = 0, psel, penable, pwrite, pready, pslverr;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb = 4'hf;
    logic [32:0] expq[$];
    int mismatches = 0, checks = 0, k;
    always #10 core_clk = ~core_clk;
    dir_apb_master i_dir_apb_master (.core_clk(core_clk), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    dir_part_identifier_word_info_rom #(.PART_NUMBER(PN), .MAJOR_REV(6'h2a), .MINOR_REV(6'h15),
        .LOW_VOLTAGE(1'b1), .FACTORY_IMAGE(IMG)) i_dir_part_identifier_word_info_rom (
        .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bulk_erase_req(bulk_erase_req));
    function automatic logic [32:0] info(input int i);
        if (i inside {'h12, 'h14, 'h15, 'h17, 'h1a, 'h1d}) return 33'h3fff;
        return 33'(IMG[i]);
    endfunction
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic op_data(input logic [17:0] a, input logic w, input logic [32:0] e,
        input logic [31:0] d);
        expq.push_back(e);
        i_dir_apb_master.xfer(a, w, d);
    endtask
    task automatic op(input logic [17:0] a, input logic w, input logic [32:0] e);
        op_data(a, w, e, $urandom);
    endtask
    always @(posedge core_clk)
        if (psel && penable && pready === 1'b1 && expq.size() > 0)
            chk({pslverr, prdata}, expq.pop_front());
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        void'($urandom(9));
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        op(18'h20018, 0, {19'h0, 2'b11, PN});
        op(18'h20014, 0, 33'h2a95);
        for (int i = 0; i < 32; i++) op(18'h20400 + 18'(4 * i), 0, info(i));
        $display("id and info test done");
        for (int i = 0; i < 4; i++) begin
            k = $urandom_range(31);
            op(18'h20400 + 18'(4 * k), 1, 33'h0);
            op(18'h20400 + 18'(4 * k), 0, info(k));
        end
        bulk_erase_req <= 1'b1;
        repeat (6) @(posedge core_clk);
        for (int i = 0; i < 10; i++) op(18'h20400 + 18'(4 * i), 0, info(i));
        op(18'h20480, 0, 33'h3);
        // Without the low byte lane the clear must be ignored
        pstrb <= 4'h0;
        op_data(18'h20480, 1, 33'h0, $urandom | 32'h3);
        op(18'h20480, 0, 33'h3);
        pstrb <= 4'hf;
        op_data(18'h20480, 1, 33'h0, $urandom | 32'h3);
        op(18'h20480, 0, 33'h0);
        op(18'h20000, 0, 33'h1_0000_0000);
        $display("write and erase test done");
        repeat (3) @(posedge core_clk);
        complete_run();
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        mismatches++;
        complete_run();
    end
endmodule
